// File: rtl/idr_slave.sv
// Identification readout slave for a two-wire bus.
// Assumes SCL and SDA arrive asynchronously; SDA is open drain, driven low only.
`timescale 1ns/1ns
module idr_slave (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [2:0] chip_select_straps_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            busy_o
);
  // ****************************************
  // Synchronise and filter
  // ****************************************
  logic [1:0] scl_sy_ff, sda_sy_ff;
  logic       scl_f_ff, sda_f_ff;
  logic [3:0] scl_cnt_ff, sda_cnt_ff;
  logic       scl_prev_ff, sda_prev_ff;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sy_ff <= 2'b11;
      sda_sy_ff <= 2'b11;
    end else begin
      scl_sy_ff <= {scl_sy_ff[0], scl_i};
      sda_sy_ff <= {sda_sy_ff[0], sda_i};
    end
  end

  // A new level is accepted only after it outlasts the spike window.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_f_ff   <= 1'b1;
      sda_f_ff   <= 1'b1;
      scl_cnt_ff <= 4'h_0;
      sda_cnt_ff <= 4'h_0;
    end else begin
      if (scl_sy_ff[1] == scl_f_ff) scl_cnt_ff <= 4'h_0;
      else if (scl_cnt_ff == 4'(idr_pkg::SPIKE_CYC - 1)) begin
        scl_f_ff   <= scl_sy_ff[1];
        scl_cnt_ff <= 4'h_0;
      end else scl_cnt_ff <= scl_cnt_ff + 4'h_1;
      if (sda_sy_ff[1] == sda_f_ff) sda_cnt_ff <= 4'h_0;
      else if (sda_cnt_ff == 4'(idr_pkg::SPIKE_CYC - 1)) begin
        sda_f_ff   <= sda_sy_ff[1];
        sda_cnt_ff <= 4'h_0;
      end else sda_cnt_ff <= sda_cnt_ff + 4'h_1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_f_ff;
      sda_prev_ff <= sda_f_ff;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_f_ff & ~scl_prev_ff;
  assign scl_fall  = ~scl_f_ff & scl_prev_ff;
  assign start_det = scl_f_ff & scl_prev_ff & sda_prev_ff & ~sda_f_ff;
  assign stop_det  = scl_f_ff & scl_prev_ff & ~sda_prev_ff & sda_f_ff;

  function automatic logic [7:0] id_byte(input logic [1:0] idx);
    case (idx)
      2'h_0:   id_byte = idr_pkg::ID_BYTE0;
      2'h_1:   id_byte = idr_pkg::ID_BYTE1;
      default: id_byte = idr_pkg::ID_BYTE2;
    endcase
  endfunction : id_byte

  // ****************************************
  // Protocol state machine
  // ****************************************
  idr_pkg::idr_state_t state_ff, ack_ret_ff;
  logic [7:0] sh_ff;
  logic [2:0] bit_ff;
  logic [1:0] byte_ff;
  logic [7:0] tx_byte;
  logic [7:0] first_byte;

  assign tx_byte    = id_byte(byte_ff);
  assign first_byte = id_byte(2'h_0);

  // The identifier lives only in the constant function; no path writes it.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff   <= idr_pkg::IDR_IDLE;
      ack_ret_ff <= idr_pkg::IDR_IDLE;
      sh_ff      <= 8'h_00;
      bit_ff     <= idr_pkg::BIT_RST;
      byte_ff    <= 2'h_0;
      sda_o      <= 1'b0;
      sda_oe_o   <= 1'b0;
    end else if (stop_det) begin
      state_ff <= idr_pkg::IDR_IDLE;
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      bit_ff   <= idr_pkg::BIT_RST;
      sda_oe_o <= 1'b0;
      // A repeated start goes to the read identifier only after the address word or a master not-acknowledge.
      state_ff <= (state_ff == idr_pkg::IDR_WAIT_RS) ? idr_pkg::IDR_RX_RD : idr_pkg::IDR_RX_RSV;
    end else begin
      case (state_ff)
        idr_pkg::IDR_IDLE, idr_pkg::IDR_WAIT_RS: begin
          sda_oe_o <= 1'b0;
        end
        idr_pkg::IDR_RX_RSV, idr_pkg::IDR_RX_ADDR, idr_pkg::IDR_RX_RD: begin
          if (scl_rise) begin
            sh_ff  <= {sh_ff[6:0], sda_f_ff};
            bit_ff <= bit_ff - 3'h_1;
          end
          if (scl_rise && bit_ff == 3'h_0) begin
            state_ff <= idr_pkg::IDR_ACK;
            case (state_ff)
              idr_pkg::IDR_RX_RSV:
                ack_ret_ff <= ({sh_ff[6:0], sda_f_ff} == idr_pkg::RSV_WR_ID)
                              ? idr_pkg::IDR_RX_ADDR : idr_pkg::IDR_IDLE;
              idr_pkg::IDR_RX_ADDR:
                ack_ret_ff <= (sh_ff[6:3] == idr_pkg::DEV_TYPE
                               && sh_ff[2:0] == chip_select_straps_i)
                              ? idr_pkg::IDR_WAIT_RS : idr_pkg::IDR_IDLE;
              default:
                ack_ret_ff <= ({sh_ff[6:0], sda_f_ff} == idr_pkg::RSV_RD_ID)
                              ? idr_pkg::IDR_TX : idr_pkg::IDR_IDLE;
            endcase
          end
        end
        idr_pkg::IDR_ACK: begin
          if (scl_fall) begin
            if (ack_ret_ff == idr_pkg::IDR_IDLE) begin
              state_ff <= idr_pkg::IDR_IDLE;
            end else if (!sda_oe_o) begin
              sda_o    <= 1'b0;
              sda_oe_o <= 1'b1;
            end else begin
              bit_ff   <= idr_pkg::BIT_RST;
              state_ff <= ack_ret_ff;
              if (ack_ret_ff == idr_pkg::IDR_TX) begin
                byte_ff  <= 2'h_0;
                sda_o    <= 1'b0;
                sda_oe_o <= ~first_byte[7];
              end else sda_oe_o <= 1'b0;
            end
          end
        end
        idr_pkg::IDR_TX: begin
          if (scl_fall) begin
            if (bit_ff == 3'h_0) begin
              sda_oe_o <= 1'b0;
              state_ff <= idr_pkg::IDR_MACK;
            end else begin
              sda_oe_o <= ~tx_byte[bit_ff - 3'h_1];
              bit_ff   <= bit_ff - 3'h_1;
            end
          end
        end
        idr_pkg::IDR_MACK: begin
          // The bit counter arrives here at zero; an acknowledge re-arms it without driving an ack of our own.
          if (scl_rise) begin
            if (sda_f_ff) begin
              state_ff <= idr_pkg::IDR_WAIT_RS;
            end else begin
              byte_ff <= (byte_ff == idr_pkg::BYTE_LAST) ? 2'h_0 : byte_ff + 2'h_1;
              bit_ff  <= idr_pkg::BIT_RST;
            end
          end
          if (scl_fall && bit_ff == idr_pkg::BIT_RST) begin
            state_ff <= idr_pkg::IDR_TX;
            sda_o    <= 1'b0;
            sda_oe_o <= ~tx_byte[7];
          end
        end
        default: state_ff <= idr_pkg::IDR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) busy_o <= 1'b0;
    else busy_o <= (state_ff != idr_pkg::IDR_IDLE);
  end

  // ****************************************
  // Checks
  // ****************************************
  a_drive_low_only: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    sda_oe_o |-> !sda_o) else $error("sda driven high");
  a_stop_releases: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    stop_det |=> !sda_oe_o && state_ff == idr_pkg::IDR_IDLE) else $error("stop not honoured");
  a_spike_ignored: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $changed(scl_f_ff) |-> $past(scl_sy_ff[1], idr_pkg::SPIKE_CYC) == scl_f_ff) else $error("filter glitch");
  a_sda_spike_ignored: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $changed(sda_f_ff) |-> $past(sda_sy_ff[1], idr_pkg::SPIKE_CYC) == sda_f_ff) else $error("sda filter glitch");
  a_bad_rsv_idle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_ff == idr_pkg::IDR_RX_RSV && scl_rise && bit_ff == 3'h_0
    && {sh_ff[6:0], sda_f_ff} != idr_pkg::RSV_WR_ID && !start_det && !stop_det
    |=> ack_ret_ff == idr_pkg::IDR_IDLE) else $error("bad reserved id accepted");
  a_addr_match: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_ff == idr_pkg::IDR_RX_ADDR && scl_rise && bit_ff == 3'h_0 && !start_det && !stop_det
    |=> (ack_ret_ff == idr_pkg::IDR_WAIT_RS) == ($past(sh_ff[6:3]) == idr_pkg::DEV_TYPE
        && $past(sh_ff[2:0]) == chip_select_straps_i)) else $error("address match wrong");
  a_wrap_first: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_ff == idr_pkg::IDR_MACK && scl_rise && !sda_f_ff && byte_ff == idr_pkg::BYTE_LAST
    && !start_det && !stop_det |=> byte_ff == 2'h_0) else $error("no wrap");
  a_nack_ends: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_ff == idr_pkg::IDR_MACK && scl_rise && sda_f_ff && !start_det && !stop_det
    |=> state_ff == idr_pkg::IDR_WAIT_RS) else $error("nack ignored");
  a_next_byte: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_ff == idr_pkg::IDR_MACK && scl_fall && bit_ff == idr_pkg::BIT_RST && !start_det && !stop_det
    |=> state_ff == idr_pkg::IDR_TX && sda_oe_o == !$past(tx_byte[7])) else $error("next byte not loaded");
  a_ack_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_ff == idr_pkg::IDR_ACK && ack_ret_ff != idr_pkg::IDR_IDLE && scl_fall && !sda_oe_o
    && !start_det && !stop_det |=> sda_oe_o && !sda_o) else $error("ack missing");
  c_tx_entered: cover property (@(posedge clk_sys_i) state_ff == idr_pkg::IDR_TX);
  c_wrap: cover property (@(posedge clk_sys_i) state_ff == idr_pkg::IDR_MACK && byte_ff == idr_pkg::BYTE_LAST
    && scl_rise && !sda_f_ff);
  c_nack: cover property (@(posedge clk_sys_i) state_ff == idr_pkg::IDR_MACK && scl_rise && sda_f_ff);
  c_refused: cover property (@(posedge clk_sys_i) state_ff == idr_pkg::IDR_ACK && ack_ret_ff == idr_pkg::IDR_IDLE
    && scl_fall);
endmodule : idr_slave

// File: rtl/idr_pkg.sv
// Constants for the two-wire identification readout slave.
// Assumes a 100 MHz system clock that oversamples the bus pins.
//
// Functional notes
// - Hold a fixed three-byte identifier, maker code then product code.
// - Identifier is read-only; the identification sequence only yields read data.
// - Start then reserved byte F8H is acknowledged in the ninth bit.
// - Address word follows; its read/write bit is ignored and it is acknowledged.
// - Repeated start then F9H is acknowledged; device then drives data.
// - Shift out identifier bytes first to third, sampling master acknowledge each.
// - An acknowledge after the third byte wraps to the first byte again.
// - Pulses of 50 ns or less on clock and data are ignored.
// - Respond only if type field is 1010 and next bits match chip_select_straps.
// - Acknowledge by driving data low during the ninth clock after each word.
package idr_pkg;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         SPIKE_NS      = 50;
  // Longest ignored pulse rounds down; a level must persist one cycle longer.
  localparam int         SPIKE_CYC     = (SPIKE_NS / CLK_PERIOD_NS) + 1;
  localparam logic [7:0] RSV_WR_ID     = 8'h_f8;
  localparam logic [7:0] RSV_RD_ID     = 8'h_f9;
  localparam logic [3:0] DEV_TYPE      = 4'h_a;
  // Identifier bytes: arbitrary neutral values.
  localparam logic [7:0] ID_BYTE0      = 8'h_5a;
  localparam logic [7:0] ID_BYTE1      = 8'h_12;
  localparam logic [7:0] ID_BYTE2      = 8'h_34;
  localparam logic [2:0] BIT_RST       = 3'h_7;
  localparam logic [1:0] BYTE_LAST     = 2'h_2;

  typedef enum logic [2:0] {
    IDR_IDLE, IDR_RX_RSV, IDR_RX_ADDR, IDR_WAIT_RS, IDR_RX_RD, IDR_TX, IDR_ACK, IDR_MACK
  } idr_state_t;
endpackage : idr_pkg

// File: bench/idr_master_model.sv
// Bus master model that drives the identification readout slave.
// Assumes the bench resolves SDA as a pulled-up wire and calls these tasks in turn.
`timescale 1ns/1ns
module idr_master_model (
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  // ****************
  // Bus phases
  // ****************
  // SDA is only ever pulled low or released, so the master never fights a slave that holds it low.
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  // One bit: data settles mid low phase, the reply is taken just past mid high phase.
  // Delays are whole multiples of 10 ns, so every pin change stays a fixed 3 ns after a system clock edge.
  task automatic bit_x(input logic b, output logic r);
    #60 sda_oe_o = ~b;
    #60 scl_o = 1'b1;
    #70 r = sda_i;
    #60 scl_o = 1'b0;
  endtask : bit_x

  // The clock rises only after the slave has dropped its acknowledge, so a repeated start is never seen as a stop.
  task automatic start;
    #60 sda_oe_o = 1'b0;
    #60 scl_o = 1'b1;
    #60 sda_oe_o = 1'b1;
    #60 scl_o = 1'b0;
  endtask : start

  task automatic stop;
    #60 sda_oe_o = 1'b1;
    #60 scl_o = 1'b1;
    #60 sda_oe_o = 1'b0;
    #120;
  endtask : stop

  task automatic glitch;
    #40 scl_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask : glitch

  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_o);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ack_in, ack_o);
  endtask : xfer
endmodule : idr_master_model

// File: bench/tb.sv
// Self-checking bench for the identification readout slave.
// Assumes the slave and the master model share one pulled-up SDA wire.
`timescale 1ns/1ns
module tb;
  logic       clk_sys_i;
  logic       nrst_i;
  logic [2:0] straps;
  logic       scl;
  logic       m_oe;
  logic       sda_o;
  logic       sda_oe;
  logic       busy;
  int         error_cnt;
  int         samples_checked;
  wire        sda = (sda_oe ? sda_o : 1'b1) & ~m_oe;

  idr_slave dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
    .chip_select_straps_i(straps), .sda_o(sda_o), .sda_oe_o(sda_oe), .busy_o(busy));
  idr_master_model mst (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Once a byte is refused the slave idles until the repeated start, then takes the next byte as the reserved byte, so every later acknowledge is expected high.
  task automatic ident(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n, input logic g);
    logic [7:0] rx;
    logic       a0, a1, a2, ok0, ok1, ok2;
    logic [7:0] id [3] = '{idr_pkg::ID_BYTE0, idr_pkg::ID_BYTE1, idr_pkg::ID_BYTE2};
    ok0 = (b0 === idr_pkg::RSV_WR_ID);
    ok1 = ok0 && (b1[7:1] === {idr_pkg::DEV_TYPE, straps});
    ok2 = ok1 && (b2 === idr_pkg::RSV_RD_ID);
    mst.start();
    if (g) mst.glitch();
    mst.xfer(b0, 1'b1, rx, a0);
    mst.xfer(b1, 1'b1, rx, a1);
    mst.start();
    mst.xfer(b2, 1'b1, rx, a2);
    chk({5'h_0, a0, a1, a2}, {5'h_0, ~ok0, ~ok1, ~ok2});
    for (int i = 0; i < n; i++) begin
      mst.xfer(8'h_ff, i == n - 1, rx, a0);
      chk(rx, id[i % 3]);
    end
    mst.stop();
    chk({6'h_0, sda_oe, busy}, 8'h_00);
  endtask : ident

  // ****************
  // Scenarios
  // ****************
  task automatic t_read;
    ident(idr_pkg::RSV_WR_ID, {idr_pkg::DEV_TYPE, straps, 1'b0}, idr_pkg::RSV_RD_ID, 3, 1'b0);
    $display("Test read done");
  endtask : t_read

  task automatic t_wrap;
    ident(idr_pkg::RSV_WR_ID, {idr_pkg::DEV_TYPE, straps, 1'b1}, idr_pkg::RSV_RD_ID, 7, 1'b0);
    $display("Test wrap done");
  endtask : t_wrap

  task automatic t_refuse;
    ident({idr_pkg::DEV_TYPE, straps, 1'b0}, idr_pkg::RSV_WR_ID, idr_pkg::RSV_RD_ID, 0, 1'b0);
    ident(idr_pkg::RSV_WR_ID, {4'h_b, straps, 1'b0}, idr_pkg::RSV_RD_ID, 0, 1'b0);
    ident(idr_pkg::RSV_WR_ID, {idr_pkg::DEV_TYPE, ~straps, 1'b0}, idr_pkg::RSV_RD_ID, 0, 1'b0);
    ident(idr_pkg::RSV_WR_ID, {idr_pkg::DEV_TYPE, straps, 1'b1}, {idr_pkg::DEV_TYPE, straps, 1'b1}, 0, 1'b0);
    straps = 3'h_2;
    ident(idr_pkg::RSV_WR_ID, {idr_pkg::DEV_TYPE, 3'h_2, 1'b0}, idr_pkg::RSV_RD_ID, 3, 1'b0);
    $display("Test refuse done");
  endtask : t_refuse

  task automatic t_glitch;
    ident(idr_pkg::RSV_WR_ID, {idr_pkg::DEV_TYPE, straps, 1'b0}, idr_pkg::RSV_RD_ID, 3, 1'b1);
    $display("Test glitch done");
  endtask : t_glitch

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    nrst_i          = 1'b0;
    straps          = 3'h_5;
    error_cnt       = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_sys_i);
    #3 nrst_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #3;
    t_read;
    t_wrap;
    t_refuse;
    t_glitch;
    report_and_stop;
  end

  // The whole run needs about 100 us of bus time; the margin covers a slow slave.
  initial begin
    #400_000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop;
  end
endmodule : tb
